// [common/mbd_pkg.sv]
/*
 * constants and types of the media block message decoder: descriptor and
 * header field positions, register offsets and reset values.
 * assumes one 40 MHz clock domain shared with the message source.
 */
package mbd_pkg;
	// ==========================================================
	// descriptor fields
	localparam int MBD_DESC_OVR_BIT = 10;
	localparam int MBD_DESC_STRIDE_BIT = 9;
	localparam int MBD_DESC_OFFSET_BIT = 8;
	// ==========================================================
	// header fields
	localparam int MBD_TAG_MSB = 7;
	localparam int MBD_CP_PTR_MSB = 31;
	localparam int MBD_CP_PTR_LSB = 5;
	localparam int MBD_CP_FMT_MSB = 3;
	localparam int MBD_CP_FMT_LSB = 2;
	localparam int MBD_CP_AOI_BIT = 1;
	localparam int MBD_CP_EN_BIT = 0;
	localparam int MBD_BH_MSB = 21;
	localparam int MBD_BH_LSB = 16;
	localparam int MBD_BW_MSB = 4;
	localparam int MBD_OFS_MSB = 30;
	// pixel-mask grid: 8 dwords wide, 4 rows tall
	localparam int MBD_GRID_COLS = 8;
	localparam int MBD_GRID_ROWS = 4;
	localparam logic [5:0] MBD_PM_WIDTH = 6'h20;
	localparam logic [6:0] MBD_PM_HEIGHT = 7'h04;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] MBD_REG_CTRL = 8'h00;
	localparam logic [7:0] MBD_REG_SURF_H = 8'h04;
	localparam logic [7:0] MBD_REG_SURF_W = 8'h08;
	localparam logic [7:0] MBD_REG_STATUS = 8'h0c;
	localparam logic [7:0] MBD_REG_DERIVED = 8'h10;
	localparam int MBD_CTRL_FULLHIST_BIT = 0;
	localparam int MBD_SURF_STRIDE_BIT = 16;
	localparam int MBD_SURF_OFFSET_BIT = 17;
	localparam logic [31:0] MBD_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] MBD_SURF_H_RST = 32'h0000_0000;
	localparam logic [31:0] MBD_SURF_W_RST = 32'h0000_0000;
	// ==========================================================
	// enumerations
	typedef enum logic {
		MBD_MODE_NORMAL = 1'b0,
		MBD_MODE_PIXEL_MASK = 1'b1
	} mbd_mode_e;
	typedef enum logic [1:0] {
		MBD_FMT_422_8 = 2'b00,
		MBD_FMT_444_8 = 2'b01,
		MBD_FMT_422_16 = 2'b10,
		MBD_FMT_444_16 = 2'b11
	} mbd_fmt_e;
endpackage

// [sim/mbd_decoder_asserts.sv]
/* port assertions for the media block message decoder.
   assumes one clock domain; bound to mbd_decoder below. */
`timescale 1ns/1ps
module mbd_decoder_chk
	import mbd_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_ack_out,
	input wire logic msg_valid_in,
	input wire logic msg_write_in,
	input wire logic msg_mode_in,
	input wire logic [31:0] msg_desc_in,
	input wire logic [31:0] msg_hdr0_in,
	input wire logic [31:0] msg_hdr2_in,
	input wire logic [31:0] msg_hdr3_in,
	input wire logic [31:0] msg_hdr5_in,
	input wire logic dec_valid_out,
	input wire logic dec_stride_out,
	input wire logic dec_stride_offset_out,
	input wire logic [7:0] dec_tag_out,
	input wire logic dec_cp_enable_out,
	input wire logic [5:0] dec_blk_width_out,
	input wire logic [6:0] dec_blk_height_out,
	input wire logic [31:0] dec_pixel_we_out,
	input wire logic [30:0] dec_x_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// ========
	// sequences
	sequence s_take;
		msg_valid_in;
	endsequence
	sequence s_over;
		msg_valid_in && msg_desc_in[MBD_DESC_OVR_BIT];
	endsequence
	sequence s_dims;
		msg_valid_in && !msg_mode_in;
	endsequence
	// ========
	// properties
	AST_WB_ACK:
		assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=>
		wb_ack_out ##1 !wb_ack_out) else $error("bad ack");
	AST_ANSWER:
		assert property (s_take |=> dec_valid_out) else $error("no answer");
	AST_QUIET:
		assert property (!msg_valid_in |=> !dec_valid_out && $stable(dec_x_out))
		else $error("spurious decode");
	AST_STRIDE:
		assert property (s_over |=> dec_stride_out == $past(msg_desc_in[9]))
		else $error("bad stride");
	AST_OFFSET:
		assert property (s_over |=> dec_stride_offset_out ==
		($past(msg_desc_in[9]) & $past(msg_desc_in[8]))) else $error("bad ofs");
	AST_TAG:
		assert property (s_take |=> dec_tag_out == $past(msg_hdr5_in[7:0]))
		else $error("bad tag");
	AST_CP_EN:
		assert property (s_take |=> dec_cp_enable_out ==
		($past(msg_write_in) & $past(msg_hdr3_in[0])))
		else $error("bad cp enable");
	AST_WIDTH:
		assert property (s_dims |=> dec_blk_width_out ==
		{1'b0, $past(msg_hdr2_in[4:0])} + 6'h01) else $error("bad width");
	AST_HEIGHT:
		assert property (s_dims |=> dec_blk_height_out ==
		{1'b0, $past(msg_hdr2_in[21:16])} + 7'h01) else $error("bad height");
	AST_READ_ALL:
		assert property (s_take and !msg_write_in |=>
		dec_pixel_we_out == 32'hffff_ffff) else $error("read masked");
	AST_X:
		assert property (s_take |=> dec_x_out == $past(msg_hdr0_in[30:0]))
		else $error("bad x");
endmodule // mbd_decoder_chk
bind mbd_decoder mbd_decoder_chk u_chk (.*);

// [sim/mbd_thread_model.sv]
/* thread model: issues decoder messages from tasks.
   assumes it shares clk_in with the decoder. */
`timescale 1ns/1ps
module mbd_thread_model (
	input wire logic clk_in,
	output logic vld_out,
	output logic wr_out,
	output logic md_out,
	output logic [31:0] d_out,
	output logic [31:0] x_out,
	output logic [31:0] y_out,
	output logic [31:0] h2_out,
	output logic [31:0] h3_out,
	output logic [31:0] h5_out,
	output logic [63:0] px_out
);
	// no pitch control field is ever produced here
	initial begin
		{vld_out, wr_out, md_out, d_out, x_out} = '0;
		{y_out, h2_out, h3_out, h5_out, px_out} = '0;
	end
	// ========
	// one message; valid stays up until idle, so calls may go back to back
	task automatic send(input logic w, m, input logic [31:0] d, x, y,
		input logic [31:0] h2, h3, h5, input logic [63:0] p);
		@(posedge clk_in);
		vld_out <= 1'b1;
		wr_out <= w;
		md_out <= m;
		d_out <= d;
		x_out <= m ? x & ~32'h1f : (w ? x & ~32'h3 : x);
		y_out <= m ? y & ~32'h3 : y;
		h2_out <= (w && !m) ? h2 | 32'h3 : h2;
		h3_out <= h3;
		h5_out <= h5;
		px_out <= p;
	endtask
	// fields mean nothing outside valid, so show them inverted
	task automatic idle();
		@(posedge clk_in);
		vld_out <= 1'b0;
		{d_out, x_out, y_out, h2_out} <= ~{d_out, x_out, y_out, h2_out};
		{h3_out, h5_out, px_out} <= ~{h3_out, h5_out, px_out};
	endtask
endmodule // mbd_thread_model

// [sim/test_mbd_decoder.sv]
/* self-checking bench for the media block message decoder.
   assumes the thread model drives messages and the checker is bound. */
`timescale 1ns/1ps
module test_mbd_decoder
	import mbd_pkg::*;
;
	logic clk_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	logic [7:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in, wb_dat_out, q;
	logic msg_valid_in, msg_write_in, msg_mode_in, dec_valid_out;
	logic [31:0] msg_desc_in, msg_hdr0_in, msg_hdr1_in, msg_hdr2_in;
	logic [31:0] msg_hdr3_in, msg_hdr5_in, dec_pixel_we_out;
	logic [63:0] msg_pixel_in;
	logic dec_stride_out, dec_stride_offset_out, dec_cp_enable_out;
	logic dec_luma_hist_out, dec_write_drop_out;
	logic [16:0] dec_height_out;
	logic [7:0] dec_tag_out;
	logic [26:0] dec_cp_state_ptr_out;
	logic [1:0] dec_cp_format_out;
	logic [5:0] dec_blk_width_out, dec_row_pitch_out;
	logic [6:0] dec_blk_height_out;
	logic [11:0] dec_xfer_bytes_out;
	logic [30:0] dec_x_out, dec_y_out, dec_read_x_out, dec_read_y_out;
	logic [15:0] dec_chan_y0_out, dec_chan_y1_out, dec_chan_u_out;
	logic [15:0] dec_chan_v_out, dec_chan_a_out;
	logic [79:0] ex, chan;
	int bad_count = 0, checked = 0, nm = 0, cyc = 0, p, r, c, bh;
	logic [3:0] wsel = 4'hf;
	localparam logic [63:0] PX = 64'h8877_6655_4433_2211;
	assign chan = {dec_chan_a_out, dec_chan_v_out, dec_chan_u_out,
		dec_chan_y1_out, dec_chan_y0_out};

	mbd_decoder #(.SURF_DIM_W(16)) dut (.*);
	mbd_thread_model tm (.clk_in(clk_in), .vld_out(msg_valid_in),
		.wr_out(msg_write_in), .md_out(msg_mode_in), .d_out(msg_desc_in),
		.x_out(msg_hdr0_in), .y_out(msg_hdr1_in), .h2_out(msg_hdr2_in),
		.h3_out(msg_hdr3_in), .h5_out(msg_hdr5_in), .px_out(msg_pixel_in));
	// ========
	// tasks
	task automatic end_of_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [79:0] e, s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		wb_sel_in <= wsel;
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		if (n == 50) chk("wb_ack", 1, 0);
	endtask
	task automatic msg(input logic w, m, input logic [31:0] d, x, y,
		input logic [31:0] h2, h3, h5);
		tm.send(w, m, d, x, y, h2, h3, h5, PX);
		tm.idle();
		@(negedge clk_in);
		nm++;
		chk("valid", 1, dec_valid_out);
	endtask
	function automatic logic [15:0] b8(input int n);
		return {8'h0, PX[n * 8 +: 8]};
	endfunction
	// ========
	// clock, timeout and sequence
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		reset_n_in = 1'b0;
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
		wb_sel_in = 4'hf;
		repeat (10) @(posedge clk_in);
		reset_n_in <= 1'b1;
		wb(0, MBD_REG_CTRL, 0);
		chk("ctrl", MBD_CTRL_RST, q);
		wb(0, MBD_REG_SURF_H, 0);
		chk("surf_h", MBD_SURF_H_RST, q);
		wb(1, 8'h20, 32'hffff_ffff);
		wb(0, 8'h20, 0);
		chk("unmapped", 0, q);
		wb(1, MBD_REG_STATUS, 32'h1234);
		wb(0, MBD_REG_STATUS, 0);
		chk("status", 0, q);
		for (int i = 0; i < 8; i++) begin
			wb(1, MBD_REG_SURF_H, {14'h0, i[0], i[1], 16'd479});
			msg(0, 0, {21'h0, i[2], i[0], !i[1], 8'h0}, 0, 0, 0, 0, 0);
			chk("stride", i[2] ? i[0] : i[1], dec_stride_out);
			chk("offset", i[0] & (i[2] ? !i[1] : i[1]),
				dec_stride_offset_out);
			p = !i[2] || i[1] == i[0] ? 480 : (i[1] ? 960 : 240);
			chk("height", p, dec_height_out);
			wb(0, MBD_REG_DERIVED, 0);
			chk("derived", p, q);
		end
		for (int w = 0; w < 32; w++) begin
			bh = w < 4 ? 63 : (w < 8 ? 31 : (w < 16 ? 15 : 7));
			msg(0, 0, 0, 0, 0, {10'h0, bh[5:0], 11'h0, w[4:0]}, 0, 0);
			p = 1;
			while (p < w + 1) p = p * 2;
			chk("width", w + 1, dec_blk_width_out);
			chk("rows", bh + 1, dec_blk_height_out);
			chk("pitch", p, dec_row_pitch_out);
			chk("bytes", p * (bh + 1), dec_xfer_bytes_out);
		end
		msg(0, 1, 0, 0, 0, 32'h1, 0, 0);
		chk("mask_read", 32'hffff_ffff, dec_pixel_we_out);
		chk("mask_bytes", 128, dec_xfer_bytes_out);
		chk("mask_width", MBD_PM_WIDTH, dec_blk_width_out);
		for (int b = 0; b < 32; b++) begin
			r = 2 * b[3] + b[1];
			c = 4 * b[4] + 2 * b[2] + b[0];
			msg(1, 1, 0, 0, 0, 32'h1 << b, 0, 0);
			chk("mask_we", 32'h1 << (r * 8 + c), dec_pixel_we_out);
		end
		for (int f = 0; f < 4; f++) begin
			wb(1, MBD_REG_CTRL, {31'h0, f[1]});
			msg(1, 0, 0, 0, 0, 0, {27'h2d2d2d2, 1'b0, f[1:0], f[0], 1'b1}, 0);
			case (f)
			0: ex = {16'h0, b8(3), b8(1), b8(2), b8(0)};
			1: ex = {b8(3), b8(0), b8(1), 16'h0, b8(2)};
			2: ex = {16'h0, PX[63:48], PX[31:16], PX[47:32], PX[15:0]};
			default: ex = {PX[63:48], PX[47:32], PX[15:0], 16'h0, PX[31:16]};
			endcase
			chk("chan", ex, chan);
			chk("fmt", f, dec_cp_format_out);
			chk("ptr", 27'h2d2d2d2, dec_cp_state_ptr_out);
			chk("luma", f[0] | f[1], dec_luma_hist_out);
		end
		wb(1, MBD_REG_CTRL, 0);
		msg(0, 0, 0, 0, 0, 0, 32'hffff_ffff, 0);
		chk("cp_rd", 0, {dec_cp_enable_out, dec_cp_format_out,
			dec_cp_state_ptr_out});
		chk("chan_rd", 0, chan);
		// low byte enable only: upper bytes must keep their reset value
		wsel = 4'h1;
		wb(1, MBD_REG_SURF_W, 32'hffff_ff63);
		wsel = 4'hf;
		wb(0, MBD_REG_SURF_W, 0);
		chk("sel", 99, q);
		msg(0, 0, 0, 32'hffff_fffb, 32'd1000, 0, 0, 0);
		chk("x", 31'h7fff_fffb, dec_x_out);
		chk("y", 31'd1000, dec_y_out);
		chk("rd_xy", 479, {dec_read_x_out, dec_read_y_out});
		msg(0, 0, 0, 200, 7, 0, 0, 0);
		chk("rd_x", 99, dec_read_x_out);
		chk("rd_y", 7, dec_read_y_out);
		msg(1, 0, 0, 200, 0, 0, 0, 0);
		chk("drop", 1, dec_write_drop_out);
		msg(1, 0, 0, 96, 8, 0, 32'h1, 0);
		chk("keep", 0, dec_write_drop_out);
		chk("x_cp", 96, dec_x_out);
		tm.send(0, 0, 0, 0, 0, 0, 0, 32'hffff_ffa5, PX);
		tm.send(0, 0, 0, 0, 0, 0, 0, 32'h3c, PX);
		@(negedge clk_in);
		chk("tag", 8'ha5, dec_tag_out);
		tm.idle();
		@(negedge clk_in);
		chk("tag", {1'b1, 8'h3c}, {dec_valid_out, dec_tag_out});
		@(negedge clk_in);
		chk("idle", 0, dec_valid_out);
		wb(0, MBD_REG_STATUS, 0);
		chk("status", nm + 2, q[15:0]);
		// second reset in mid-run: outputs and registers back to reset
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		@(negedge clk_in);
		chk("rst_we", 32'hffff_ffff, dec_pixel_we_out);
		chk("rst_dec", 0, {dec_valid_out, dec_tag_out, dec_x_out,
			dec_height_out});
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		wb(0, MBD_REG_SURF_W, 0);
		chk("surf_w_rst", MBD_SURF_W_RST, q);
		wb(0, MBD_REG_STATUS, 0);
		chk("status_rst", 0, q);
		end_of_test();
	end
endmodule // test_mbd_decoder

// [verilog/mbd_decoder.sv]
/*
 * media block read/write message decoder: decodes descriptor and header
 * of one message per clk_in cycle with msg_valid_in high, one cycle later on dec_*_out.
 * assumes the message source runs on clk_in; surface state and the
 * full-image histogram setting come from wishbone registers.
 */
`timescale 1ns/1ps
module mbd_decoder
	import mbd_pkg::*;
#(
	parameter int SURF_DIM_W = 16
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic msg_valid_in,
	input wire logic msg_write_in,
	input wire logic msg_mode_in,
	input wire logic [31:0] msg_desc_in,
	input wire logic [31:0] msg_hdr0_in,
	input wire logic [31:0] msg_hdr1_in,
	input wire logic [31:0] msg_hdr2_in,
	input wire logic [31:0] msg_hdr3_in,
	input wire logic [31:0] msg_hdr5_in,
	input wire logic [63:0] msg_pixel_in,
	output logic dec_valid_out,
	output logic dec_stride_out,
	output logic dec_stride_offset_out,
	output logic [SURF_DIM_W:0] dec_height_out,
	output logic [7:0] dec_tag_out,
	output logic dec_cp_enable_out,
	output logic [26:0] dec_cp_state_ptr_out,
	output logic [1:0] dec_cp_format_out,
	output logic dec_luma_hist_out,
	output logic [5:0] dec_blk_width_out,
	output logic [6:0] dec_blk_height_out,
	output logic [5:0] dec_row_pitch_out,
	output logic [11:0] dec_xfer_bytes_out,
	output logic [31:0] dec_pixel_we_out,
	output logic [30:0] dec_x_out,
	output logic [30:0] dec_y_out,
	output logic [30:0] dec_read_x_out,
	output logic [30:0] dec_read_y_out,
	output logic dec_write_drop_out,
	output logic [15:0] dec_chan_y0_out,
	output logic [15:0] dec_chan_y1_out,
	output logic [15:0] dec_chan_u_out,
	output logic [15:0] dec_chan_v_out,
	output logic [15:0] dec_chan_a_out
);

	// ==========================================================
	// elaboration checks
	// wider heights would run into the surface stride bits
	if (SURF_DIM_W < 1 || SURF_DIM_W > MBD_SURF_STRIDE_BIT) begin : g_bad_dim
		$error("SURF_DIM_W must lie in 1..16");
	end

	// ==========================================================
	// state
	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] surf_h;
		logic [31:0] surf_w;
		logic [15:0] msg_count;
		logic [31:0] wb_dat;
		logic wb_ack;
		logic valid;
		logic stride;
		logic stride_offset;
		logic [SURF_DIM_W:0] height;
		logic [7:0] tag;
		logic cp_en;
		logic [26:0] cp_ptr;
		logic [1:0] cp_fmt;
		logic luma_hist;
		logic [5:0] blk_w;
		logic [6:0] blk_h;
		logic [5:0] pitch;
		logic [11:0] xfer;
		logic [31:0] pix_we;
		logic [30:0] x;
		logic [30:0] y;
		logic [30:0] rd_x;
		logic [30:0] rd_y;
		logic wr_drop;
		logic [15:0] ch_y0;
		logic [15:0] ch_y1;
		logic [15:0] ch_u;
		logic [15:0] ch_v;
		logic [15:0] ch_a;
	} mbd_state_s;

	mbd_state_s st;
	mbd_state_s next_st;

	// ==========================================================
	// helpers
	// smallest power of two not below the width in bytes
	function automatic logic [5:0] mbd_pow2_pitch(input logic [5:0] w);
		logic [5:0] p;
		p = 6'h01;
		for (int i = 0; i < 5; i++) begin
			if (p < w) begin
				p = {p[4:0], 1'b0};
			end
		end
		return p;
	endfunction

	// grid position to mask bit: col bit2 -> 16, row bit1 -> 8,
	// col bit1 -> 4, row bit0 -> 2, col bit0 -> 1
	function automatic int mbd_mask_bit(input int r, input int c);
		return ((c / 4) * 16) + ((r / 2) * 8) + (((c / 2) % 2) * 4)
			+ ((r % 2) * 2) + (c % 2);
	endfunction

	logic [31:0] grid_mask;
	for (genvar gr = 0; gr < MBD_GRID_ROWS; gr++) begin : g_row
		for (genvar gc = 0; gc < MBD_GRID_COLS; gc++) begin : g_col
			// grid entry row gr, column gc takes its own mask bit
			assign grid_mask[gr * MBD_GRID_COLS + gc] =
				msg_hdr2_in[mbd_mask_bit(gr, gc)];
		end
	end

	// ==========================================================
	// next state
	logic wb_req;
	logic [31:0] wr_mask;
	logic use_stride;
	logic use_offset;
	logic surf_stride;
	logic [SURF_DIM_W:0] h1;
	logic [SURF_DIM_W:0] hd;
	logic [SURF_DIM_W:0] surf_w0;
	logic signed [31:0] sx;
	logic signed [31:0] sy;
	logic signed [31:0] w_last;
	logic signed [31:0] h_last;
	logic cp_on;
	logic [5:0] bw;
	logic [6:0] bh;
	logic [5:0] bp;

	always_comb begin
		next_st = st;
		wb_req = wb_cyc_in && wb_stb_in && !st.wb_ack;
		wr_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
			{8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
		// wishbone: one ack per request, dropped the cycle after
		next_st.wb_ack = wb_req;
		next_st.wb_dat = 32'h0000_0000;
		if (wb_req && wb_we_in) begin
			case (wb_adr_in)
				MBD_REG_CTRL: begin
					next_st.ctrl = (st.ctrl & ~wr_mask) | (wb_dat_in & wr_mask);
				end
				MBD_REG_SURF_H: begin
					next_st.surf_h = (st.surf_h & ~wr_mask) | (wb_dat_in & wr_mask);
				end
				MBD_REG_SURF_W: begin
					next_st.surf_w = (st.surf_w & ~wr_mask) | (wb_dat_in & wr_mask);
				end
				default: begin
				end
			endcase
		end
		if (wb_req && !wb_we_in) begin
			case (wb_adr_in)
				MBD_REG_CTRL: next_st.wb_dat = st.ctrl;
				MBD_REG_SURF_H: next_st.wb_dat = st.surf_h;
				MBD_REG_SURF_W: next_st.wb_dat = st.surf_w;
				MBD_REG_STATUS: next_st.wb_dat = {16'h0000, st.msg_count};
				MBD_REG_DERIVED: begin
					next_st.wb_dat = 32'(st.height);
				end
				// unmapped addresses answer with zero
				default: next_st.wb_dat = 32'h0000_0000;
			endcase
		end

		// stride selection: override or surface state
		surf_stride = st.surf_h[MBD_SURF_STRIDE_BIT];
		if (msg_desc_in[MBD_DESC_OVR_BIT]) begin
			use_stride = msg_desc_in[MBD_DESC_STRIDE_BIT];
			use_offset = msg_desc_in[MBD_DESC_OFFSET_BIT];
		end else begin
			use_stride = surf_stride;
			use_offset = st.surf_h[MBD_SURF_OFFSET_BIT];
		end
		// the start offset only means something with stride 1
		use_offset = use_offset && use_stride;

		// derived 1-based height
		h1 = {1'b0, st.surf_h[SURF_DIM_W-1:0]} + 1'b1;
		hd = h1;
		if (msg_desc_in[MBD_DESC_OVR_BIT]) begin
			if (!surf_stride && use_stride) begin
				// odd h1 truncates; the sender keeps it even
				hd = {1'b0, h1[SURF_DIM_W:1]};
			end else if (surf_stride && !use_stride) begin
				hd = {h1[SURF_DIM_W-1:0], 1'b0};
			end
		end

		// colour processing only on writes with the enable set
		cp_on = msg_write_in && msg_hdr3_in[MBD_CP_EN_BIT];

		// dword 2 carries either dimensions or a mask, never both
		if (mbd_mode_e'(msg_mode_in) == MBD_MODE_PIXEL_MASK) begin
			bw = MBD_PM_WIDTH;
			bh = MBD_PM_HEIGHT;
		end else begin
			bw = {1'b0, msg_hdr2_in[MBD_BW_MSB:0]} + 6'h01;
			bh = {1'b0, msg_hdr2_in[MBD_BH_MSB:MBD_BH_LSB]} + 7'h01;
		end
		// rows spaced by the power-of-two pitch, both directions
		bp = mbd_pow2_pitch(bw);

		// signed offsets, sign taken from bit 30
		sx = {msg_hdr0_in[MBD_OFS_MSB], msg_hdr0_in[MBD_OFS_MSB:0]};
		sy = {msg_hdr1_in[MBD_OFS_MSB], msg_hdr1_in[MBD_OFS_MSB:0]};
		surf_w0 = {1'b0, st.surf_w[SURF_DIM_W-1:0]};
		w_last = 32'(surf_w0);
		h_last = 32'(hd) - 32'sd1;

		next_st.valid = msg_valid_in;
		if (msg_valid_in) begin
			next_st.msg_count = st.msg_count + 16'h0001;
			next_st.stride = use_stride;
			next_st.stride_offset = use_offset;
			next_st.height = hd;
			next_st.tag = msg_hdr5_in[MBD_TAG_MSB:0];
			next_st.cp_en = cp_on;
			// pointer is meaningless on reads or with colour off
			next_st.cp_ptr = cp_on ?
				msg_hdr3_in[MBD_CP_PTR_MSB:MBD_CP_PTR_LSB] : 27'h0000000;
			next_st.cp_fmt = cp_on ?
				msg_hdr3_in[MBD_CP_FMT_MSB:MBD_CP_FMT_LSB] : 2'h0;
			// full-image histogram takes every luma pixel
			next_st.luma_hist = cp_on &&
				(st.ctrl[MBD_CTRL_FULLHIST_BIT] || msg_hdr3_in[MBD_CP_AOI_BIT]);
			next_st.blk_w = bw;
			next_st.blk_h = bh;
			next_st.pitch = bp;
			// size fixed by block parameters alone, no exec mask
			next_st.xfer = 12'(bp) * 12'(bh);
			// mask gates writes only; reads get every pixel
			if (msg_write_in &&
				mbd_mode_e'(msg_mode_in) == MBD_MODE_PIXEL_MASK) begin
				next_st.pix_we = grid_mask;
			end else begin
				next_st.pix_we = 32'hffff_ffff;
			end
			// offset kept in message units, conversion happens later
			next_st.x = msg_hdr0_in[MBD_OFS_MSB:0];
			next_st.y = msg_hdr1_in[MBD_OFS_MSB:0];
			// read corner clamped to nearest edge
			if (sx < 0) begin
				next_st.rd_x = 31'h00000000;
			end else if (sx > w_last) begin
				next_st.rd_x = 31'(w_last);
			end else begin
				next_st.rd_x = sx[30:0];
			end
			if (sy < 0) begin
				next_st.rd_y = 31'h00000000;
			end else if (sy > h_last) begin
				next_st.rd_y = 31'(h_last);
			end else begin
				next_st.rd_y = sy[30:0];
			end
			// corner outside the surface: the write is dropped
			next_st.wr_drop = msg_write_in &&
				(sx < 0 || sy < 0 || sx > w_last || sy > h_last);
			next_st.ch_y0 = 16'h0000;
			next_st.ch_y1 = 16'h0000;
			next_st.ch_u = 16'h0000;
			next_st.ch_v = 16'h0000;
			next_st.ch_a = 16'h0000;
			if (cp_on) begin
				case (mbd_fmt_e'(msg_hdr3_in[MBD_CP_FMT_MSB:MBD_CP_FMT_LSB]))
					MBD_FMT_422_8: begin
						next_st.ch_v = {8'h00, msg_pixel_in[31:24]};
						next_st.ch_y1 = {8'h00, msg_pixel_in[23:16]};
						next_st.ch_u = {8'h00, msg_pixel_in[15:8]};
						next_st.ch_y0 = {8'h00, msg_pixel_in[7:0]};
					end
					MBD_FMT_444_8: begin
						next_st.ch_a = {8'h00, msg_pixel_in[31:24]};
						next_st.ch_y0 = {8'h00, msg_pixel_in[23:16]};
						next_st.ch_u = {8'h00, msg_pixel_in[15:8]};
						next_st.ch_v = {8'h00, msg_pixel_in[7:0]};
					end
					MBD_FMT_422_16: begin
						next_st.ch_v = msg_pixel_in[63:48];
						next_st.ch_y1 = msg_pixel_in[47:32];
						next_st.ch_u = msg_pixel_in[31:16];
						next_st.ch_y0 = msg_pixel_in[15:0];
					end
					MBD_FMT_444_16: begin
						next_st.ch_a = msg_pixel_in[63:48];
						next_st.ch_v = msg_pixel_in[47:32];
						next_st.ch_y0 = msg_pixel_in[31:16];
						next_st.ch_u = msg_pixel_in[15:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st <= '0;
			st.ctrl <= MBD_CTRL_RST;
			st.surf_h <= MBD_SURF_H_RST;
			st.surf_w <= MBD_SURF_W_RST;
			st.pix_we <= 32'hffff_ffff;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs, all straight from the state flops
	assign wb_dat_out = st.wb_dat;
	assign wb_ack_out = st.wb_ack;
	assign dec_valid_out = st.valid;
	assign dec_stride_out = st.stride;
	assign dec_stride_offset_out = st.stride_offset;
	assign dec_height_out = st.height;
	assign dec_tag_out = st.tag;
	assign dec_cp_enable_out = st.cp_en;
	assign dec_cp_state_ptr_out = st.cp_ptr;
	assign dec_cp_format_out = st.cp_fmt;
	assign dec_luma_hist_out = st.luma_hist;
	assign dec_blk_width_out = st.blk_w;
	assign dec_blk_height_out = st.blk_h;
	assign dec_row_pitch_out = st.pitch;
	assign dec_xfer_bytes_out = st.xfer;
	assign dec_pixel_we_out = st.pix_we;
	assign dec_x_out = st.x;
	assign dec_y_out = st.y;
	assign dec_read_x_out = st.rd_x;
	assign dec_read_y_out = st.rd_y;
	assign dec_write_drop_out = st.wr_drop;
	assign dec_chan_y0_out = st.ch_y0;
	assign dec_chan_y1_out = st.ch_y1;
	assign dec_chan_u_out = st.ch_u;
	assign dec_chan_v_out = st.ch_v;
	assign dec_chan_a_out = st.ch_a;

endmodule // mbd_decoder
